//--- bench/asrt_remote.sv
`timescale 1ns/10ps
// far end in loopback: echoes the line, or holds it at space
module asrt_remote (
    input  wire logic line_in,  // transmitter output
    input  wire logic hold_low, // force space on command
    output logic      line_out  // receiver input
);
    // echo, optionally broken
    assign line_out = line_in & ~hold_low;
endmodule : asrt_remote

//--- bench/tb_asrt_top.sv
`timescale 1ns/10ps
module tb_asrt_top;
    import asrt_pkg::*;
    logic         clk, arst_n, master_reset, tx_clock_16x, rx_clock_16x, brk;
    logic         tx_load_strobe_n, control_load_strobe, rx_avail_clear_n;
    logic         rx_data_out_en_n, status_out_en_n, rx_serial_in, tx_serial_out;
    logic         tx_char_done, rx_data_out_oe, status_out_oe, tx_fifo_ready;
    logic [7:0]   tx_data_in, rx_data_out, d;
    logic [15:0]  lfsr;
    asrt_ctrl_t   ctrl_in;
    asrt_status_t status_out;
    int           n_errors, check_count, cyc;

    asrt_top asrt_top_i (.clk, .arst_n, .master_reset, .tx_clock_16x, .rx_clock_16x,
        .tx_load_strobe_n, .tx_data_in, .control_load_strobe, .ctrl_in, .rx_serial_in,
        .rx_avail_clear_n, .rx_data_out_en_n, .status_out_en_n, .tx_serial_out,
        .tx_char_done, .tx_fifo_ready, .rx_data_out, .rx_data_out_oe, .status_out,
        .status_out_oe);
    asrt_remote asrt_remote_i (.line_in(tx_serial_out), .hold_low(brk),
        .line_out(rx_serial_in));

    // clocks, the 16x pair slightly apart in rate
    always #10 clk = ~clk;
    always #80 tx_clock_16x = ~tx_clock_16x;
    always #81 rx_clock_16x = ~rx_clock_16x;

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            conclude();
        end
    end

    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [7:0] expect_char(logic [7:0] v, logic [1:0] wl);
        return v & (8'hFF >> (2'h3 - wl));
    endfunction : expect_char

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic send(logic [7:0] v);
        tx_data_in <= v;
        tx_load_strobe_n <= 1'h0;
        tick(3);
        tx_load_strobe_n <= 1'h1;
        tick(3);
    endtask : send

    task automatic wait_rx();
        for (int k = 0; k < 3000 && status_out.rx_data_avail !== 1'h1; k++) tick(1);
        check("avail", status_out.rx_data_avail, 8'h01);
    endtask : wait_rx

    task automatic conclude();
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // reset, random loopback traffic, then overrun, reset and break
    initial begin
        {arst_n, master_reset, brk, clk, tx_clock_16x, rx_clock_16x} = 6'h00;
        {tx_load_strobe_n, rx_avail_clear_n, control_load_strobe} = 3'h7;
        {rx_data_out_en_n, status_out_en_n, tx_data_in} = 10'h000;
        ctrl_in = CTRL_RESET;
        lfsr = 16'h9B50;
        tick(2);
        arst_n <= 1'h1;
        tick(4);
        check("idle", {tx_serial_out, tx_char_done, status_out.tx_buffer_empty, tx_fifo_ready},
              8'h0F);
        check("oe", {rx_data_out_oe, status_out_oe}, 8'h03);
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            ctrl_in <= (i < 4) ? {i[1:0], lfsr[2:0]} : lfsr[4:0];
            tick(3);
            d = lfsr[15:8];
            send(d);
            wait_rx();
            check("eoc", tx_char_done, 8'h00);
            check("data", rx_data_out, expect_char(d, ctrl_in.word_len_sel));
            check("flags", status_out[2:0], 8'h00);
            rx_avail_clear_n <= 1'h0;
            tick(4);
            rx_avail_clear_n <= 1'h1;
            tick(1);
            check("cleared", status_out.rx_data_avail, 8'h00);
            for (int k = 0; k < 2000 && tx_char_done !== 1'h1; k++) tick(1);
            check("done", tx_char_done, 8'h01);
            tick(16);
        end
        send(8'hA5);
        send(8'h3C);
        tick(2);
        check("full", status_out.tx_buffer_empty, 8'h00);
        wait_rx();
        tick(2000);
        check("overrun", status_out.rx_overrun, 8'h01);
        check("chained", rx_data_out, expect_char(8'h3C, ctrl_in.word_len_sel));
        master_reset <= 1'h1;
        tick(3);
        master_reset <= 1'h0;
        tick(3);
        check("mreset", status_out, 8'h10);
        ctrl_in <= CTRL_RESET;
        tick(3);
        control_load_strobe <= 1'h0;
        tick(3);
        ctrl_in <= 5'h07;
        brk <= 1'h1;
        tick(20);
        brk <= 1'h0;
        tick(1500);
        check("glitch", status_out.rx_data_avail, 8'h00);
        brk <= 1'h1;
        wait_rx();
        check("break", status_out[1:0], 8'h03);
        conclude();
    end
endmodule : tb_asrt_top

//--- hw/asrt_fifo.sv
`timescale 1ns/10ps
// small synchronous fifo with valid/ready on both sides
module asrt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,        // system clock
    input  wire logic             arst_n,     // async reset, active low
    input  wire logic             flush,      // drop all content
    input  wire logic             in_valid,   // write request
    output logic                  in_ready,   // space available
    input  wire logic [WIDTH-1:0] in_data,    // write data
    output logic                  out_valid,  // word available
    input  wire logic             out_ready,  // consumer takes word
    output logic      [WIDTH-1:0] out_data    // head word
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    // full when pointers differ only in the wrap bit
    assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                         (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;
    assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

    // storage array
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

endmodule : asrt_fifo

//--- hw/asrt_pkg.sv
package asrt_pkg;

    // control bits latched by the control strobe
    typedef struct packed {
        logic [1:0] word_len_sel;       // 00=5 .. 11=8 data bits
        logic       stop_bits_select;   // 0=one stop bit, 1=two (one and a half at five bits)
        logic       parity_even_select; // 1=even, 0=odd
        logic       parity_disable;     // 1=no parity bit
    } asrt_ctrl_t;

    // status word driven onto the status outputs
    typedef struct packed {
        logic tx_buffer_empty;
        logic rx_data_avail;
        logic rx_overrun;
        logic rx_framing_err;
        logic rx_parity_err;
    } asrt_status_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} asrt_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_VERIFY, RX_DATA, RX_PARITY, RX_STOP} asrt_rx_state_t;

    // bit timing in ticks of the 16x clocks
    localparam logic [5:0] BIT_LAST   = 6'h0F;  // sixteen ticks per bit
    localparam logic [5:0] HALF_LAST  = 6'h07;  // eight ticks, start verify
    localparam logic [5:0] STOP1_LAST = 6'h0F;  // one stop bit
    localparam logic [5:0] STOP15_LAST = 6'h17; // one and a half stop bits
    localparam logic [5:0] STOP2_LAST = 6'h1F;  // two stop bits
    localparam logic [1:0] WL_FIVE    = 2'h0;   // word length code for five bits
    localparam logic [2:0] WL_BASE    = 3'h4;   // last bit index for five bits

    // control reset: eight bits, odd parity, one stop bit
    localparam asrt_ctrl_t CTRL_RESET = 5'h18;

endpackage : asrt_pkg

//--- hw/asrt_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for a bundle of pin inputs
module asrt_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,     // system clock
    input  wire logic             arst_n,  // async reset, active low
    input  wire logic [WIDTH-1:0] d_in,    // asynchronous inputs
    output logic      [WIDTH-1:0] q_out    // synchronised outputs
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= RESET_VAL;
            q_out    <= RESET_VAL;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end

endmodule : asrt_sync

//--- hw/asrt_top.sv
`timescale 1ns/10ps
// Summary of operation
// - master reset marks line, clears receive flags
// - both 16x clocks divided by sixteen
// - load strobe captures data, buffer not empty
// - idle shifter takes buffer, starts bit
// - frame is start, data lsb first, parity, stop
// - char done after last stop; chain next
// - char done holds until next start
// - idle line stays at mark level
// - start bit on tx clock falling edge
// - control strobe high latches control bits
// - word length five to eight bits
// - one, two, or one-and-half stop bits
// - parity odd, even or none
// - no parity: stop follows last data
// - data lsb first, unused bits ignored
// - received data right justified, upper zero
// - start verified after half bit low
// - parity error on mismatch, low if none
// - framing error when stop bit low
// - overrun when character lands on unread
// - data available set, host clear lowers
// - outputs enabled by active-low enables
// - word length code 00..11 gives 5..8
module asrt_top
    import asrt_pkg::*;
#(
    parameter int DATA_W     = 8,   // widest character
    parameter int FIFO_DEPTH = 16   // transmit buffer depth
) (
    input  wire logic              clk,                 // 50 MHz system clock
    input  wire logic              arst_n,              // async reset, active low
    input  wire logic              master_reset,        // pin, high resets the block
    input  wire logic              tx_clock_16x,        // pin, 16x transmit clock
    input  wire logic              rx_clock_16x,        // pin, 16x receive clock
    input  wire logic              tx_load_strobe_n,    // pin, low pulse loads data
    input  wire logic [DATA_W-1:0] tx_data_in,          // pin, lsb on bit 0
    input  wire logic              control_load_strobe, // pin, high latches control
    input  wire asrt_ctrl_t        ctrl_in,             // pins, control bits
    input  wire logic              rx_serial_in,        // pin, serial receive line
    input  wire logic              rx_avail_clear_n,    // pin, low clears data avail
    input  wire logic              rx_data_out_en_n,    // pin, low enables data out
    input  wire logic              status_out_en_n,     // pin, low enables status
    output logic                   tx_serial_out,       // serial transmit line
    output logic                   tx_char_done,        // end of character
    output logic                   tx_fifo_ready,       // transmit buffer can accept
    output logic      [DATA_W-1:0] rx_data_out,         // received character
    output logic                   rx_data_out_oe,      // high while data driven
    output asrt_status_t           status_out,          // status word
    output logic                   status_out_oe        // high while status driven
);

    localparam int SYNC_W = 14 + DATA_W;

    // right-justify an lsb-first shifted character, zero upper bits
    function automatic logic [DATA_W-1:0] justify(input logic [DATA_W-1:0] d,
                                                   input logic [1:0] wl);
        logic [2:0] sh;
        sh = 3'h3 - {1'h0, wl};
        justify = d >> sh;
    endfunction : justify

    // keep only the data bits of the selected word length
    function automatic logic [DATA_W-1:0] mask_data(input logic [DATA_W-1:0] d,
                                                     input logic [1:0] wl);
        logic [DATA_W-1:0] m;
        m = {DATA_W{1'h1}} >> (3'h3 - {1'h0, wl});
        mask_data = d & m;
    endfunction : mask_data

    // parity bit giving odd or even count of ones
    function automatic logic parity_of(input logic [DATA_W-1:0] d, input logic even);
        parity_of = (^d) ^ !even;
    endfunction : parity_of

    // synchronised pin inputs
    logic              mr_s, txc_s, rxc_s, tds_s, cs_s, rsi_s, clr_s, rde_s, swe_s;
    asrt_ctrl_t        ctrl_s;
    logic [DATA_W-1:0] txd_s;

    asrt_sync #(
        .WIDTH     (SYNC_W),
        .RESET_VAL ({1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 5'h00, 1'h1, 1'h1, 1'h1, 1'h1,
                     {DATA_W{1'h0}}})
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d_in   ({master_reset, tx_clock_16x, rx_clock_16x, tx_load_strobe_n,
                  control_load_strobe, ctrl_in, rx_serial_in, rx_avail_clear_n,
                  rx_data_out_en_n, status_out_en_n, tx_data_in}),
        .q_out  ({mr_s, txc_s, rxc_s, tds_s, cs_s, ctrl_s, rsi_s, clr_s,
                  rde_s, swe_s, txd_s})
    );

    // edge detection on synchronised clocks and strobe
    logic txc_d_reg, rxc_d_reg, tds_d_reg;
    logic tx_fall, tx_rise, rx_rise, tds_trail;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txc_d_reg <= 1'h0;
            rxc_d_reg <= 1'h0;
            tds_d_reg <= 1'h1;
        end else begin
            txc_d_reg <= txc_s;
            rxc_d_reg <= rxc_s;
            tds_d_reg <= tds_s;
        end
    end

    assign tx_fall   = txc_d_reg && !txc_s;
    assign tx_rise   = !txc_d_reg && txc_s;
    assign rx_rise   = !rxc_d_reg && rxc_s;
    assign tds_trail = !tds_d_reg && tds_s;

    // control holding register, transparent while strobe high
    asrt_ctrl_t ctrl_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (cs_s) begin
            ctrl_reg <= ctrl_s;
        end
    end

    // stop length and last data bit index from control
    logic [5:0] stop_last;
    logic [2:0] last_bit;

    always_comb begin
        last_bit = WL_BASE + {1'h0, ctrl_reg.word_len_sel};
        if (!ctrl_reg.stop_bits_select) begin
            stop_last = STOP1_LAST;
        end else if (ctrl_reg.word_len_sel == WL_FIVE) begin
            stop_last = STOP15_LAST;
        end else begin
            stop_last = STOP2_LAST;
        end
    end

    // transmit buffer between load strobe and shifter
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [DATA_W-1:0] fifo_out_data;

    asrt_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .flush     (mr_s),
        .in_valid  (tds_trail),
        .in_ready  (tx_fifo_ready),
        .in_data   (txd_s),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // transmitter state
    asrt_tx_state_t    tx_state_reg;
    logic [5:0]        tx_cnt_reg;
    logic [2:0]        tx_bit_reg;
    logic [DATA_W-1:0] tx_shift_reg;
    logic              tx_par_reg;
    logic              tx_out_reg;
    logic              tx_done_reg;
    logic              tx_stop_end;
    logic              tx_load;

    assign tx_stop_end    = (tx_state_reg == TX_STOP) && (tx_cnt_reg == stop_last);
    // shifter takes the buffer when idle or finishing a character
    assign fifo_out_ready = tx_fall && ((tx_state_reg == TX_IDLE) || tx_stop_end);
    assign tx_load        = fifo_out_valid && fifo_out_ready;

    // transmit sequencer, advances on tx clock falling edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= 6'h00;
            tx_bit_reg   <= 3'h0;
            tx_shift_reg <= '0;
            tx_par_reg   <= 1'h0;
            tx_out_reg   <= 1'h1;
        end else if (mr_s) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= 6'h00;
            tx_out_reg   <= 1'h1;
        end else if (tx_load) begin
            tx_state_reg <= TX_START;
            tx_cnt_reg   <= 6'h00;
            tx_shift_reg <= mask_data(fifo_out_data, ctrl_reg.word_len_sel);
            tx_par_reg   <= parity_of(mask_data(fifo_out_data, ctrl_reg.word_len_sel),
                                      ctrl_reg.parity_even_select);
            tx_out_reg   <= 1'h0;
        end else if (tx_fall) begin
            tx_cnt_reg <= tx_cnt_reg + 6'h01;
            unique case (tx_state_reg)
                TX_IDLE: begin
                    tx_cnt_reg <= 6'h00;
                    tx_out_reg <= 1'h1;
                end
                TX_START: begin
                    if (tx_cnt_reg == BIT_LAST) begin
                        tx_state_reg <= TX_DATA;
                        tx_cnt_reg   <= 6'h00;
                        tx_bit_reg   <= 3'h0;
                        tx_out_reg   <= tx_shift_reg[0];
                        tx_shift_reg <= tx_shift_reg >> 1;
                    end
                end
                TX_DATA: begin
                    if (tx_cnt_reg == BIT_LAST) begin
                        tx_cnt_reg <= 6'h00;
                        if (tx_bit_reg == last_bit) begin
                            if (ctrl_reg.parity_disable) begin
                                tx_state_reg <= TX_STOP;
                                tx_out_reg   <= 1'h1;
                            end else begin
                                tx_state_reg <= TX_PARITY;
                                tx_out_reg   <= tx_par_reg;
                            end
                        end else begin
                            tx_bit_reg   <= tx_bit_reg + 3'h1;
                            tx_out_reg   <= tx_shift_reg[0];
                            tx_shift_reg <= tx_shift_reg >> 1;
                        end
                    end
                end
                TX_PARITY: begin
                    if (tx_cnt_reg == BIT_LAST) begin
                        tx_state_reg <= TX_STOP;
                        tx_cnt_reg   <= 6'h00;
                        tx_out_reg   <= 1'h1;
                    end
                end
                TX_STOP: begin
                    if (tx_stop_end) begin
                        tx_state_reg <= TX_IDLE;
                        tx_cnt_reg   <= 6'h00;
                    end
                end
            endcase
        end
    end

    // end of character: rises in last half of last stop, falls at next start
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_done_reg <= 1'h1;
        end else if (mr_s) begin
            tx_done_reg <= 1'h1;
        end else if (tx_load) begin
            tx_done_reg <= 1'h0;
        end else if (tx_rise && tx_stop_end) begin
            tx_done_reg <= 1'h1;
        end
    end

    assign tx_serial_out = tx_out_reg;
    assign tx_char_done  = tx_done_reg;

    // receiver state
    asrt_rx_state_t    rx_state_reg;
    logic [5:0]        rx_cnt_reg;
    logic [2:0]        rx_bit_reg;
    logic [DATA_W-1:0] rx_shift_reg;
    logic              rx_par_reg;
    logic              rx_prev_reg;
    logic              rx_done;
    logic              rx_at_mid;

    assign rx_at_mid = rx_rise && (rx_cnt_reg == BIT_LAST);
    assign rx_done   = rx_at_mid && (rx_state_reg == RX_STOP);

    // receive sequencer, advances on rx clock rising edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 6'h00;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= '0;
            rx_par_reg   <= 1'h0;
            rx_prev_reg  <= 1'h1;
        end else if (mr_s) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 6'h00;
            rx_prev_reg  <= 1'h1;
        end else if (rx_rise) begin
            rx_prev_reg <= rsi_s;
            rx_cnt_reg  <= rx_cnt_reg + 6'h01;
            unique case (rx_state_reg)
                RX_IDLE: begin
                    rx_cnt_reg <= 6'h00;
                    if (rx_prev_reg && !rsi_s) begin
                        rx_state_reg <= RX_VERIFY;
                    end
                end
                RX_VERIFY: begin
                    if (rsi_s) begin
                        rx_state_reg <= RX_IDLE;
                    end else if (rx_cnt_reg == HALF_LAST) begin
                        rx_state_reg <= RX_DATA;
                        rx_cnt_reg   <= 6'h00;
                        rx_bit_reg   <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_reg == BIT_LAST) begin
                        rx_cnt_reg   <= 6'h00;
                        rx_shift_reg <= {rsi_s, rx_shift_reg[DATA_W-1:1]};
                        rx_bit_reg   <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == last_bit) begin
                            rx_state_reg <= ctrl_reg.parity_disable ? RX_STOP : RX_PARITY;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rx_cnt_reg == BIT_LAST) begin
                        rx_cnt_reg   <= 6'h00;
                        rx_par_reg   <= rsi_s;
                        rx_state_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_reg == BIT_LAST) begin
                        rx_state_reg <= RX_IDLE;
                        rx_cnt_reg   <= 6'h00;
                    end
                end
            endcase
        end
    end

    // receive buffer and status flags
    logic [DATA_W-1:0] rx_data_reg;
    logic              rx_avail_reg, rx_over_reg, rx_frame_reg, rx_perr_reg;
    logic [DATA_W-1:0] rx_char;

    assign rx_char = justify(rx_shift_reg, ctrl_reg.word_len_sel);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_reg  <= '0;
            rx_avail_reg <= 1'h0;
            rx_over_reg  <= 1'h0;
            rx_frame_reg <= 1'h0;
            rx_perr_reg  <= 1'h0;
        end else if (mr_s) begin
            rx_data_reg  <= '0;
            rx_avail_reg <= 1'h0;
            rx_over_reg  <= 1'h0;
            rx_frame_reg <= 1'h0;
            rx_perr_reg  <= 1'h0;
        end else if (rx_done) begin
            rx_data_reg  <= rx_char;
            rx_over_reg  <= rx_avail_reg;
            rx_frame_reg <= !rsi_s;
            rx_perr_reg  <= (parity_of(rx_char, ctrl_reg.parity_even_select) != rx_par_reg);
            rx_avail_reg <= 1'h1;
        end else if (!clr_s) begin
            rx_avail_reg <= 1'h0;
        end
    end

    // output drive and enables
    assign rx_data_out                = rx_data_reg;
    assign rx_data_out_oe             = !rde_s;
    assign status_out_oe              = !swe_s;
    assign status_out.tx_buffer_empty = !fifo_out_valid;
    assign status_out.rx_data_avail   = rx_avail_reg;
    assign status_out.rx_overrun      = rx_over_reg;
    assign status_out.rx_framing_err  = rx_frame_reg;
    assign status_out.rx_parity_err   = rx_perr_reg && !ctrl_reg.parity_disable;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_char_end;
        tx_rise && tx_stop_end;
    endsequence

    a_reset_marks_line: assert property (mr_s |=> tx_serial_out && tx_char_done
        && !status_out.rx_data_avail && !status_out.rx_overrun)
        else $error("master reset did not mark line or clear flags");
    a_load_fills_buf: assert property (tds_trail && tx_fifo_ready && !mr_s
        |=> !status_out.tx_buffer_empty)
        else $error("buffer still empty after load");
    a_start_bit_out: assert property (tx_load && !mr_s |=> !tx_serial_out && !tx_char_done)
        else $error("start bit or char done wrong after load");
    a_start_on_fall: assert property ($fell(tx_serial_out) && tx_state_reg == TX_START
        |-> $past(tx_fall))
        else $error("start bit not on tx clock falling edge");
    a_done_after_stop: assert property ((s_char_end and !mr_s) |=> tx_char_done)
        else $error("char done not raised after last stop");
    a_idle_marking: assert property (tx_state_reg == TX_IDLE && !tx_load |=> tx_serial_out)
        else $error("line not marking while idle");
    a_verify_abort: assert property (rx_rise && rx_state_reg == RX_VERIFY && rsi_s && !mr_s
        |=> rx_state_reg == RX_IDLE)
        else $error("false start not rejected");
    a_nopar_no_err: assert property (ctrl_reg.parity_disable |-> !status_out.rx_parity_err)
        else $error("parity error shown in no-parity mode");
    a_overrun_set: assert property (rx_done && rx_avail_reg && !mr_s |=> rx_over_reg[*2])
        else $error("overrun not set on unread character");
    a_avail_clear: assert property (!clr_s && !rx_done && !mr_s |=> !rx_avail_reg)
        else $error("data available not cleared");

endmodule : asrt_top
